// [hw/svt_top.sv]
// Secure vector memory, tamper erase and random generator.
// Assumes the core presents program accesses and SFR accesses on sys_clk;
// tamper and supply-good inputs are asynchronous pins.
//
// Contract
// - 48-byte internal vector memory replaces low program
// - Loader writes to vectors go inside automatically
// - Vector memory erased on unlock or tamper
// - Addresses below 30h served from vector memory
// - Vector bytes never written to external memory
// - Dummy external accesses continue during vector access
// - Vector memory used only when encryption enabled
// - Tamper input active high, any supply level
// - Tamper input debounced; short pulses rejected
// - Accepted tamper clears the security lock
// - Tamper cuts supply, floats strobes, grounds bus
// - Tamper exits 1792 machine cycles after release
// - Tamper erases key and vector memory
// - Random byte readable at SFR random_value
// - Reading random byte starts next generation
// - New byte ready about 160 us later
// - Ready flag bit 7 at 0D8h sets
// - Read before ready returns zero
// - Loader key material comes from generator
// - Locked device denies loader memory access
// - Loader re-entry picks fresh candidate key
// - Unlock lets loader overwrite external memory
`timescale 1ns/1ps
`default_nettype none
module svt_top
	import svt_pkg::*;
#(
	parameter int RAND_CYCLES = SVT_RAND_CYCLES,
	parameter int EXIT_MC = SVT_TAMPER_EXIT_MC,
	parameter int DEBOUNCE = SVT_DEBOUNCE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	// Program memory access from core / loader
	input wire logic prog_req,
	input wire logic prog_we,
	input wire logic [15:0] prog_addr,
	input wire logic [7:0] prog_wdata,
	output logic [7:0] prog_rdata,
	output logic prog_internal,
	output logic ext_req,
	output logic ext_we,
	output logic ext_dummy,
	// SFR access
	input wire logic sfr_rd,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Security state
	input wire logic lock_set,
	input wire logic unlock_req,
	input wire logic encrypt_en,
	input wire logic loader_active,
	output logic lock_q,
	output logic loader_mem_ok,
	output logic nv_overwrite_q,
	output logic [SVT_KEY_BITS-1:0] key_q,
	// Tamper pins
	input wire logic tamper_erase_input,
	input wire logic supply_good,
	output logic tamper_active,
	output logic memory_supply_output,
	output logic memory_chip_selects_oe_n,
	output logic bus_ground
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic tin_s1_q, tin_s2_q, sg_s1_q, sg_s2_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tin_s1_q <= 1'b0;
			tin_s2_q <= 1'b0;
			sg_s1_q <= 1'b0;
			sg_s2_q <= 1'b0;
		end else begin
			tin_s1_q <= tamper_erase_input;
			tin_s2_q <= tin_s1_q;
			sg_s1_q <= supply_good;
			sg_s2_q <= sg_s1_q;
		end
	end

	// ----------------------------------------
	// Debounce and tamper state
	// ----------------------------------------
	logic [15:0] deb_q;
	logic tamper_hit;
	always_ff @(posedge sys_clk) begin
		if (rst || !tin_s2_q) begin
			deb_q <= 16'h0000; // Short pulses restart the count
		end else if (deb_q != 16'(DEBOUNCE)) begin
			deb_q <= deb_q + 16'h0001;
		end
	end
	// Works from supply alone, no supply gating on acceptance
	assign tamper_hit = (deb_q == 16'(DEBOUNCE - 1)) && tin_s2_q;

	// Machine-cycle enable
	logic [3:0] mc_q;
	logic mc_en;
	always_ff @(posedge sys_clk) begin
		if (rst || mc_en) begin
			mc_q <= 4'h0;
		end else begin
			mc_q <= mc_q + 4'h1;
		end
	end
	assign mc_en = (mc_q == 4'(SVT_MC_CLOCKS - 1));

	svt_tamper_t tst_q;
	logic [11:0] exit_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tst_q <= SVT_T_IDLE;
			exit_q <= 12'h000;
		end else begin
			case (tst_q)
				SVT_T_IDLE: begin
					if (tamper_hit) begin
						tst_q <= SVT_T_ACTIVE;
					end
				end
				SVT_T_ACTIVE: begin
					if (sg_s2_q && !tin_s2_q) begin
						tst_q <= SVT_T_EXIT;
						exit_q <= 12'h000;
					end
				end
				SVT_T_EXIT: begin
					if (!sg_s2_q || tin_s2_q) begin
						tst_q <= SVT_T_ACTIVE;
					end else if (mc_en) begin
						if (exit_q == 12'(EXIT_MC - 1)) begin
							tst_q <= SVT_T_IDLE; // Leaves after full hold
						end else begin
							exit_q <= exit_q + 12'h001;
						end
					end
				end
				default: tst_q <= SVT_T_IDLE;
			endcase
		end
	end
	assign tamper_active = (tst_q != SVT_T_IDLE);

	// Erase pins while tamper holds
	assign memory_supply_output = !tamper_active;
	assign memory_chip_selects_oe_n = tamper_active;
	assign bus_ground = tamper_active;

	// ----------------------------------------
	// Security lock and key
	// ----------------------------------------
	logic unlock_evt, loader_prev_q, cand_valid_q;
	logic [SVT_KEY_BITS-1:0] cand_q;
	assign unlock_evt = (unlock_req && lock_q) || tamper_hit;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lock_q <= 1'b0;
		end else if (tamper_hit) begin
			lock_q <= 1'b0; // Tamper clears lock like unlock
		end else if (unlock_req) begin
			lock_q <= 1'b0;
		end else if (lock_set) begin
			lock_q <= 1'b1;
		end
	end
	// Locked device keeps loader off memory
	assign loader_mem_ok = loader_active && !lock_q && !tamper_active;

	// Loader erase of external memory after unlock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nv_overwrite_q <= 1'b0;
		end else if (unlock_req && lock_q) begin
			nv_overwrite_q <= 1'b1;
		end else if (!loader_active) begin
			nv_overwrite_q <= 1'b0;
		end
	end

	// Random source: free-running LFSR sampled per byte
	logic [15:0] lfsr_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lfsr_q <= SVT_LFSR_SEED;
		end else begin
			lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? SVT_LFSR_TAPS : 16'h0000);
		end
	end

	// Candidate key refresh on loader entry, install on first access
	always_ff @(posedge sys_clk) begin
		loader_prev_q <= rst ? 1'b0 : loader_active;
		if (rst) begin
			cand_q <= '0;
			cand_valid_q <= 1'b0;
			key_q <= '0;
		end else if (unlock_evt) begin
			key_q <= '0; // Key destroyed
			cand_valid_q <= 1'b0;
		end else if (loader_active && !loader_prev_q) begin
			cand_q <= {cand_q[SVT_KEY_BITS-17:0], lfsr_q}; // Key from generator
			cand_valid_q <= 1'b1; // Fresh candidate each entry
		end else if (cand_valid_q && prog_req && loader_mem_ok) begin
			key_q <= cand_q; // Installed on next loader access
			cand_valid_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Vector memory path
	// ----------------------------------------
	logic vec_hit;
	logic [7:0] vec_rdata;
	// Low region internal only with encryption on
	assign vec_hit = encrypt_en && (prog_addr < SVT_VEC_LIMIT);
	// Loader writes land inside automatically
	svt_vec_ram #(.DEPTH(SVT_VEC_BYTES)) u_vec ( // Internal vector store
		.sys_clk(sys_clk),
		.rst(rst),
		.erase(unlock_evt), // Erase on unlock or tamper
		.wr_en(prog_req && prog_we && vec_hit && !tamper_active),
		.addr(prog_addr[5:0]),
		.wr_data(prog_wdata),
		.rd_data(vec_rdata)
	);
	assign prog_rdata = vec_rdata;
	assign prog_internal = prog_req && vec_hit;
	// Bus keeps cycling; vector writes never reach it
	assign ext_req = prog_req && !tamper_active;
	assign ext_we = prog_req && prog_we && !vec_hit && !tamper_active;
	assign ext_dummy = prog_req && vec_hit && !tamper_active;

	// ----------------------------------------
	// Random value register and ready flag
	// ----------------------------------------
	logic rd_rand, ready_q;
	logic [7:0] rand_q;
	logic [15:0] gen_q;
	assign rd_rand = sfr_rd && (sfr_addr == SVT_RANDOM_VALUE_ADDR);
	always_ff @(posedge sys_clk) begin
		if (rst || rd_rand) begin
			gen_q <= 16'(RAND_CYCLES - 1); // Read restarts generation
		end else if (gen_q != 16'h0000) begin
			gen_q <= gen_q - 16'h0001; // About 160 us to develop
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ready_q <= 1'b0;
			rand_q <= SVT_RAND_EMPTY;
		end else if (gen_q == 16'h0001 && !rd_rand) begin
			ready_q <= 1'b1; // Flag sets on fresh byte
			rand_q <= lfsr_q[7:0];
		end else if (rd_rand) begin
			ready_q <= 1'b0; // Cleared by read
			rand_q <= SVT_RAND_EMPTY;
		end
	end

	// SFR read mux; unready value reads as zero
	always_comb begin
		sfr_rdata = 8'h00;
		if (sfr_addr == SVT_RANDOM_VALUE_ADDR) begin
			sfr_rdata = ready_q ? rand_q : SVT_RAND_EMPTY;
		end else if (sfr_addr == SVT_RANDOM_READY_CONTROL_ADDR) begin
			sfr_rdata[SVT_READY_BIT] = ready_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_tamper_unlock;
		@(posedge sys_clk) disable iff (rst) tamper_hit |=> !lock_q && tamper_active;
	endproperty
	a_tamper_unlock: assert property (p_tamper_unlock) else $error("Tamper did not clear lock");
	property p_tamper_pins;
		@(posedge sys_clk) disable iff (rst) tamper_active |-> !memory_supply_output && bus_ground && !ext_req;
	endproperty
	a_tamper_pins: assert property (p_tamper_pins) else $error("Tamper pins not safe");
	property p_debounce;
		@(posedge sys_clk) disable iff (rst) tamper_hit |-> $past(tin_s2_q, DEBOUNCE - 1) && tin_s2_q;
	endproperty
	a_debounce: assert property (p_debounce) else $error("Glitch accepted");
	property p_key_erase;
		@(posedge sys_clk) disable iff (rst) unlock_evt |=> key_q == '0;
	endproperty
	a_key_erase: assert property (p_key_erase) else $error("Key survived erase");
	property p_read_clears;
		@(posedge sys_clk) disable iff (rst) rd_rand |=> !ready_q [*3];
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("Ready not cleared");
	property p_zero_unready;
		@(posedge sys_clk) disable iff (rst) (sfr_addr == SVT_RANDOM_VALUE_ADDR) && !ready_q |-> sfr_rdata == 8'h00;
	endproperty
	a_zero_unready: assert property (p_zero_unready) else $error("Unready value not zero");
	property p_flag_bit;
		@(posedge sys_clk) disable iff (rst) (sfr_addr == SVT_RANDOM_READY_CONTROL_ADDR) |-> sfr_rdata[SVT_READY_BIT] == ready_q;
	endproperty
	a_flag_bit: assert property (p_flag_bit) else $error("Flag bit wrong");
	property p_no_ext_vec_write;
		@(posedge sys_clk) disable iff (rst) prog_req && vec_hit |-> !ext_we && (ext_dummy || tamper_active);
	endproperty
	a_no_ext_vec_write: assert property (p_no_ext_vec_write) else $error("Vector hit leaked");
	property p_locked_loader;
		@(posedge sys_clk) disable iff (rst) lock_q |-> !loader_mem_ok;
	endproperty
	a_locked_loader: assert property (p_locked_loader) else $error("Loader access while locked");
	c_tamper: cover property (@(posedge sys_clk) disable iff (rst) tamper_hit);
	c_ready: cover property (@(posedge sys_clk) disable iff (rst) $rose(ready_q));
	c_exit: cover property (@(posedge sys_clk) disable iff (rst) tst_q == SVT_T_EXIT ##1 tst_q == SVT_T_IDLE);
endmodule
`default_nettype wire

// [hw/svt_pkg.sv]
// Package for the secure vector / tamper / random block.
// Assumes one 100 MHz clock; machine cycle enable derived inside the top.
package svt_pkg;
	// ----------------------------------------
	// Register map (special-function space)
	// ----------------------------------------
	localparam logic [7:0] SVT_RANDOM_VALUE_ADDR = 8'hcf;
	localparam logic [7:0] SVT_RANDOM_READY_CONTROL_ADDR = 8'hd8;
	localparam int SVT_READY_BIT = 7;
	localparam logic [7:0] SVT_RAND_EMPTY = 8'h00;
	// ----------------------------------------
	// Vector memory
	// ----------------------------------------
	localparam int SVT_VEC_BYTES = 48;
	localparam logic [15:0] SVT_VEC_LIMIT = 16'h0030;
	localparam logic [7:0] SVT_VEC_CLEAR = 8'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SVT_CLK_MHZ = 100;
	localparam int SVT_RAND_TIME_US = 160;
	localparam int SVT_RAND_CYCLES = SVT_RAND_TIME_US * SVT_CLK_MHZ;
	localparam int SVT_MC_CLOCKS = 12;
	localparam int SVT_TAMPER_EXIT_MC = 1792;
	localparam int SVT_DEBOUNCE_CYCLES = 16;
	localparam int SVT_KEY_BITS = 80;
	localparam logic [15:0] SVT_LFSR_SEED = 16'hace1;
	localparam logic [15:0] SVT_LFSR_TAPS = 16'hb400;
	// ----------------------------------------
	// Tamper state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		SVT_T_IDLE = 3'b001,
		SVT_T_ACTIVE = 3'b010,
		SVT_T_EXIT = 3'b100
	} svt_tamper_t;
endpackage

// [hw/svt_vec_ram.sv]
// 48-byte vector memory with whole-array erase.
// Assumes sys_clk domain; erase has priority over write.
`timescale 1ns/1ps
`default_nettype none
module svt_vec_ram
	import svt_pkg::*;
#(
	parameter int DEPTH = SVT_VEC_BYTES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic erase,
	input wire logic wr_en,
	input wire logic [5:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	logic [7:0] mem_q [DEPTH];

	// ----------------------------------------
	// Storage, erased per entry
	// ----------------------------------------
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge sys_clk) begin
			if (rst || erase) begin
				mem_q[i] <= SVT_VEC_CLEAR; // Contents destroyed at once
			end else if (wr_en && addr == 6'(i)) begin
				mem_q[i] <= wr_data;
			end
		end
	end

	// Registered read port
	always_ff @(posedge sys_clk) begin
		if (rst || erase) begin
			rd_data <= SVT_VEC_CLEAR;
		end else if (int'(addr) < DEPTH) begin
			rd_data <= mem_q[addr];
		end else begin
			rd_data <= SVT_VEC_CLEAR;
		end
	end
endmodule
`default_nettype wire

// [verification/svt_ext_model.sv]
// Model of the external tamper sensor and the bytewide NV RAM.
// Assumes the bench commands the sensor; counts real powered bus writes.
`timescale 1ns/1ps
`default_nettype none
module svt_ext_model (
	input wire logic sys_clk,
	input wire logic trip,
	input wire logic vcc_ok,
	input wire logic ext_req,
	input wire logic ext_we,
	input wire logic ext_dummy,
	input wire logic memory_supply_output,
	output logic tamper_erase_input,
	output logic supply_good,
	output int nv_writes
);
	// Sensor and supply pins, skewed off the clock edge
	assign #3 tamper_erase_input = trip;
	assign #4 supply_good = vcc_ok;
	// Memory keeps only real writes while it is powered
	initial nv_writes = 0;
	always @(posedge sys_clk) begin
		if (ext_req && ext_we && !ext_dummy && memory_supply_output) begin
			nv_writes <= nv_writes + 1;
		end
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the vector memory, tamper erase and random generator.
// Assumes shortened counts: 20-cycle random, 3-cycle debounce, 4 machine cycle exit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import svt_pkg::*;
	localparam int RC = 20;
	localparam int EMC = 4;
	logic sys_clk, rst, prog_req, prog_we, sfr_rd, lock_set, unlock_req, encrypt_en, loader_active, trip, vcc_ok;
	logic [15:0] prog_addr;
	logic [7:0] prog_wdata, sfr_addr, prog_rdata, sfr_rdata;
	logic prog_internal, ext_req, ext_we, ext_dummy, lock_q, loader_mem_ok, nv_overwrite_q, tamper_active;
	logic memory_supply_output, memory_chip_selects_oe_n, bus_ground, tamper_erase_input, supply_good;
	logic [SVT_KEY_BITS-1:0] key_q, key_snap;
	logic [79:0] exp_q[$];
	logic [3:0] sel_q[$];
	logic [7:0] vd[2];
	logic [7:0] raw_byte;
	int nv_writes, nv_exp, error_cnt, comparisons, seed, n;
	svt_top #(.RAND_CYCLES(RC), .EXIT_MC(EMC), .DEBOUNCE(3)) i_dut (.sys_clk, .rst, .prog_req, .prog_we,
		.prog_addr, .prog_wdata, .prog_rdata, .prog_internal, .ext_req, .ext_we, .ext_dummy, .sfr_rd,
		.sfr_wr(1'b0), .sfr_addr, .sfr_wdata(8'h00), .sfr_rdata, .lock_set, .unlock_req, .encrypt_en,
		.loader_active, .lock_q, .loader_mem_ok, .nv_overwrite_q, .key_q, .tamper_erase_input, .supply_good,
		.tamper_active, .memory_supply_output, .memory_chip_selects_oe_n, .bus_ground);
	svt_ext_model i_ext (.sys_clk, .trip, .vcc_ok, .ext_req, .ext_we, .ext_dummy, .memory_supply_output,
		.tamper_erase_input, .supply_good, .nv_writes);
	// ----------------------------------------
	// Result checking
	// ----------------------------------------
	// Selects the observed result named by a note
	function automatic logic [79:0] seen(input logic [3:0] s);
		case (s)
			4'h0: seen = {72'h0, prog_rdata};
			4'h1: seen = {79'h0, prog_internal};
			4'h2: seen = {78'h0, ext_req, ext_we};
			4'h3: seen = {72'h0, sfr_rdata};
			4'h4: seen = {79'h0, sfr_rdata[7]};
			4'h5: seen = {77'h0, memory_supply_output, memory_chip_selects_oe_n, bus_ground};
			4'h6: seen = {79'h0, lock_q};
			4'h7: seen = {79'h0, |key_q};
			4'h8: seen = {79'h0, key_q === key_snap};
			4'h9: seen = {79'h0, nv_overwrite_q};
			4'ha: seen = {79'h0, loader_mem_ok};
			4'hb: seen = {48'h0, nv_writes};
			4'hd: seen = {79'h0, ext_dummy};
			default: seen = {79'h0, tamper_active};
		endcase
	endfunction
	task automatic compare(input logic [79:0] got, input logic [79:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Notes wait in order until the settled half of the cycle
	always @(negedge sys_clk) begin
		while (sel_q.size() > 0) compare(seen(sel_q.pop_front()), exp_q.pop_front());
	end
	// CRC-16 style hash of a raw generator byte before software uses it
	function automatic logic [7:0] hash8(input logic [7:0] raw);
		logic [15:0] crc;
		crc = 16'hffff;
		for (int i = 0; i < 8; i++) begin
			crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ raw[i]) ? 16'h1021 : 16'h0000);
		end
		hash8 = crc[7:0];
	endfunction
	task automatic note(input logic [3:0] s, input logic [79:0] v);
		sel_q.push_back(s);
		exp_q.push_back(v);
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// One program access; bus gives the expected external request and write
	task automatic prog_acc(input logic we, input logic [15:0] a, input logic [7:0] d, input logic [7:0] rd,
		input logic [1:0] bus);
		@(posedge sys_clk);
		prog_req <= 1'b1;
		prog_we <= we;
		prog_addr <= a;
		prog_wdata <= d;
		note(4'h1, {79'h0, a < SVT_VEC_LIMIT && encrypt_en});
		note(4'h2, {78'h0, bus});
		note(4'hd, {79'h0, a < SVT_VEC_LIMIT && encrypt_en});
		@(posedge sys_clk);
		prog_req <= 1'b0;
		if (!we) note(4'h0, {72'h0, rd});
	endtask
	task automatic sfr_acc(input logic rd, input logic [7:0] a);
		@(posedge sys_clk);
		sfr_rd <= rd;
		sfr_addr <= a;
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#20us;
		error_cnt++;
		$display("Error at %0t: timeout", $time);
		finish_test;
	end
	initial begin
		{prog_req, prog_we, sfr_rd, lock_set, unlock_req, loader_active, trip} = '0;
		{prog_addr, prog_wdata, sfr_addr, key_snap} = '0;
		rst = 1'b1;
		vcc_ok = 1'b1;
		encrypt_en = 1'b1;
		seed = 97;
		nv_exp = 0;
		error_cnt = 0;
		comparisons = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		// Random byte: early read, restart, ready flag
		sfr_acc(1'b1, SVT_RANDOM_VALUE_ADDR);
		note(4'h3, 80'h0);
		sfr_acc(1'b0, SVT_RANDOM_READY_CONTROL_ADDR);
		note(4'h4, 80'h0);
		repeat (RC - 4) @(posedge sys_clk);
		note(4'h4, 80'h0);
		repeat (3) @(posedge sys_clk);
		note(4'h4, 80'h1);
		sfr_acc(1'b1, SVT_RANDOM_VALUE_ADDR);
		@(negedge sys_clk);
		raw_byte = sfr_rdata;
		sfr_acc(1'b1, SVT_RANDOM_VALUE_ADDR);
		note(4'h3, 80'h0);
		sfr_acc(1'b0, SVT_RANDOM_READY_CONTROL_ADDR);
		note(4'h4, 80'h0);
		$display("Test random done");
		// Vector memory edges, external boundary, plain mode
		vd[0] = 8'($random(seed)) ^ hash8(raw_byte);
		vd[1] = 8'($random(seed));
		prog_acc(1'b1, 16'h0000, vd[0], 8'h00, 2'b10);
		prog_acc(1'b1, 16'h002f, vd[1], 8'h00, 2'b10);
		prog_acc(1'b0, 16'h0000, 8'h00, vd[0], 2'b10);
		prog_acc(1'b0, 16'h002f, 8'h00, vd[1], 2'b10);
		prog_acc(1'b1, SVT_VEC_LIMIT, vd[1], 8'h00, 2'b11);
		encrypt_en <= 1'b0;
		prog_acc(1'b1, 16'h0005, vd[0], 8'h00, 2'b11);
		encrypt_en <= 1'b1;
		nv_exp = 2;
		@(posedge sys_clk);
		note(4'hb, 80'(nv_exp));
		$display("Test vector done");
		// Loader key install and re-entry
		loader_active <= 1'b1;
		prog_acc(1'b1, 16'h0003, vd[1], 8'h00, 2'b10);
		note(4'h7, 80'h1);
		@(negedge sys_clk);
		key_snap = key_q;
		@(posedge sys_clk);
		loader_active <= 1'b0;
		@(posedge sys_clk);
		loader_active <= 1'b1;
		repeat (2) @(posedge sys_clk);
		note(4'h8, 80'h1);
		prog_acc(1'b0, 16'h0003, 8'h00, vd[1], 2'b10);
		note(4'h8, 80'h0);
		// Lock denies the loader; unlock erases vectors
		loader_active <= 1'b0;
		lock_set <= 1'b1;
		@(posedge sys_clk);
		lock_set <= 1'b0;
		loader_active <= 1'b1;
		note(4'h6, 80'h1);
		@(posedge sys_clk);
		note(4'ha, 80'h0);
		loader_active <= 1'b0;
		unlock_req <= 1'b1;
		@(posedge sys_clk);
		unlock_req <= 1'b0;
		note(4'h6, 80'h0);
		note(4'h9, 80'h1);
		@(posedge sys_clk);
		prog_acc(1'b0, 16'h0000, 8'h00, 8'h00, 2'b10);
		$display("Test lock done");
		// Tamper: glitch rejected, sustained event, exit count
		loader_active <= 1'b1;
		prog_acc(1'b1, 16'h0010, vd[0], 8'h00, 2'b10);
		loader_active <= 1'b0;
		lock_set <= 1'b1;
		trip <= 1'b1;
		@(posedge sys_clk);
		lock_set <= 1'b0;
		trip <= 1'b0;
		repeat (10) @(posedge sys_clk);
		note(4'hc, 80'h0);
		vcc_ok <= 1'b0;
		trip <= 1'b1;
		for (n = 0; n < 20 && tamper_active !== 1'b1; n++) @(posedge sys_clk);
		note(4'hc, 80'h1);
		note(4'h6, 80'h0);
		note(4'h7, 80'h0);
		note(4'h5, 80'h3);
		trip <= 1'b0;
		repeat (100) @(posedge sys_clk);
		note(4'hc, 80'h1);
		vcc_ok <= 1'b1;
		repeat ((EMC - 1) * SVT_MC_CLOCKS + 3) @(posedge sys_clk);
		note(4'hc, 80'h1);
		for (n = 0; n < 20 && tamper_active !== 1'b0; n++) @(posedge sys_clk);
		note(4'hc, 80'h0);
		note(4'h5, 80'h4);
		prog_acc(1'b0, 16'h0010, 8'h00, 8'h00, 2'b10);
		$display("Test tamper done");
		repeat (2) @(posedge sys_clk);
		finish_test;
	end
endmodule
`default_nettype wire
